/* File: rtl/bmc_map.svh */
`ifndef BMC_MAP_SVH
`define BMC_MAP_SVH
// Register indices; the byte address is four times the index
`define BMC_IDX_MODE_CTRL 4'h0
`define BMC_IDX_LEVEL_SEL 4'h1
`define BMC_IDX_WARN_LVL 4'h8
`define BMC_IDX_WARN_INT 4'h9
`define BMC_IDX_WARN_FLAGS 4'hA
`define BMC_IDX_WARN_STAT 4'hB
`define BMC_IDX_KEY 4'hC
`define BMC_IDX_SLEEP 4'hD
// Fuse field positions
`define BMC_FUSE_SLEEP_LSB 0
`define BMC_FUSE_ACTIVE_LSB 2
`define BMC_FUSE_SAMP_BIT 4
`define BMC_FUSE_LVL_LSB 5
// Mode codes
`define BMC_MODE_OFF 2'h0
`define BMC_MODE_ON 2'h1
`define BMC_MODE_SAMPLED 2'h2
`define BMC_MODE_ON_HOLD 2'h3
// Crossing codes
`define BMC_CROSS_ABOVE 2'h0
`define BMC_CROSS_BELOW 2'h1
`define BMC_CROSS_EITHER 2'h2
// Protection key value and window
`define BMC_IO_KEY 8'hD8
`define BMC_KEY_WINDOW 3'h4
`define BMC_WARN_LVL_RESET 2'h0
`define BMC_INT_RESET 3'h0
`endif

/* File: rtl/bmc_pkg.sv */
package bmc_pkg;
  typedef logic [1:0] bmc_mode_t;
  typedef enum logic [0:0] {BMC_AWAKE, BMC_ASLEEP} bmc_pwr_t;
endpackage : bmc_pkg

/* File: rtl/bmc_top.sv */
// Operation
// - Threshold, sample rate, awake and sleep modes load from fuse at reset.
// - Threshold level and awake mode are fuse-fixed; CPU writes ignored.
// - Sleep mode resets from fuse, changeable later by protected write.
// - Warning enable turns monitor on; crossing field picks trigger condition.
// - Monitor follows detector mode: off when detector off, sampled when sampled.
// - Either-direction config sets flag on enable outside sampled mode; single-direction does not.
// - Level codes 0,1,2 give 5,15,25 percent above threshold; 3 reserved.
// - In sampled mode only crossing code 1 raises an interrupt.
// - A configured crossing sets the flag only while warning enable is set.
// - Request is high exactly while enabled and flag set.
// - Single interrupt vector at offset zero for the warning crossing.
// - Deep sleep uses sleep-mode setting; wake returns to awake setting.
// - Protected write needs key within four instructions before it.
// - Unkeyed protected write completes on bus but changes nothing.
// - Sleep-mode field is guarded by the I/O register key class.
// - Sample-rate bit 4 read-only: 0 is 1 kHz, 1 is 125 Hz.
// - Awake mode bits 3:2: off, on, sampled, on with wake held.
// - Sleep mode bits 1:0: off, on, sampled; code 3 reserved.
// - Threshold level three bits, read-only, fuse-loaded.
// - Crossing codes: 0 from above, 1 from below, 2 either.
// - Status reads one if supply was below warning threshold at the last monitor look.
//
// Implementation choice: the APB slave port.
`include "bmc_map.svh"
module bmc_top
  import bmc_pkg::*;
#(
  parameter int FUSE_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [5:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [FUSE_W-1:0] brownout_config_fuse,
  input wire logic fuse_valid,
  input wire logic deep_sleep,
  input wire logic cpu_instr_done,
  input wire logic supply_below_warning,
  input wire logic sample_strobe,
  output logic [1:0] detector_mode,
  output logic sample_rate_select,
  output logic [2:0] threshold_level,
  output logic [1:0] warning_level_select,
  output logic monitor_enable,
  output logic wake_hold,
  output logic warning_irq
);

  if (FUSE_W < 8) begin : g_fuse_w_chk
    $error("fuse word must hold eight bits");
  end

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire logic [3:0] idx = paddr[5:2];
  wire logic acc = psel & penable;
  wire logic wr = acc & pwrite;
  wire logic wr_lvl = wr && idx == `BMC_IDX_WARN_LVL;
  wire logic wr_int = wr && idx == `BMC_IDX_WARN_INT;
  wire logic wr_flag = wr && idx == `BMC_IDX_WARN_FLAGS;
  wire logic wr_key = wr && idx == `BMC_IDX_KEY;
  wire logic wr_mode = wr && idx == `BMC_IDX_MODE_CTRL;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // ----------------------------------------------------------------
  // Fuse-loaded fields
  // ----------------------------------------------------------------
  logic loaded_q;
  logic [1:0] active_q;
  logic [1:0] sleep_q;
  logic samp_q;
  logic [2:0] lvl_q;
  logic [2:0] key_cnt_q;
  // Capture once, on the first cycle after reset with the fuse word valid; never writable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loaded_q <= 1'b0;
      active_q <= `BMC_MODE_OFF;
      samp_q <= 1'b0;
      lvl_q <= 3'h0;
    end else if (!loaded_q && fuse_valid) begin
      loaded_q <= 1'b1;
      active_q <= brownout_config_fuse[`BMC_FUSE_ACTIVE_LSB +: 2];
      samp_q <= brownout_config_fuse[`BMC_FUSE_SAMP_BIT];
      lvl_q <= brownout_config_fuse[`BMC_FUSE_LVL_LSB +: 3];
    end
  end

  // ----------------------------------------------------------------
  // Key window and protected sleep-mode field
  // ----------------------------------------------------------------
  wire logic key_open = key_cnt_q != 3'h0;
  wire logic key_ok = wr_key && pwdata[7:0] == `BMC_IO_KEY;
  wire logic sleep_wr = wr_mode && key_open && pwdata[1:0] != `BMC_MODE_ON_HOLD;
  logic [2:0] key_cnt_d;
  // Count instructions down; the protected write itself closes the window
  assign key_cnt_d = key_ok ? `BMC_KEY_WINDOW :
                     sleep_wr ? 3'h0 :
                     (key_open && cpu_instr_done) ? key_cnt_q - 3'h1 : key_cnt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) key_cnt_q <= 3'h0;
    else key_cnt_q <= key_cnt_d;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sleep_q <= `BMC_MODE_OFF;
    else if (!loaded_q && fuse_valid) sleep_q <= brownout_config_fuse[`BMC_FUSE_SLEEP_LSB +: 2];
    else if (loaded_q && sleep_wr) sleep_q <= pwdata[1:0];
  end

  // ----------------------------------------------------------------
  // Monitor control registers
  // ----------------------------------------------------------------
  logic [1:0] wlvl_q;
  logic ie_q;
  logic [1:0] cfg_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wlvl_q <= `BMC_WARN_LVL_RESET;
      ie_q <= 1'b0;
      cfg_q <= 2'h0;
    end else begin
      if (wr_lvl) wlvl_q <= pwdata[1:0];
      if (wr_int) {cfg_q, ie_q} <= pwdata[2:0];
    end
  end

  // ----------------------------------------------------------------
  // Effective mode and crossing detection
  // ----------------------------------------------------------------
  wire bmc_pwr_t pwr = deep_sleep ? BMC_ASLEEP : BMC_AWAKE;
  wire bmc_mode_t mode_eff = (pwr == BMC_ASLEEP) ? sleep_q : active_q;
  wire logic det_on = loaded_q && mode_eff != `BMC_MODE_OFF;
  wire logic sampled = mode_eff == `BMC_MODE_SAMPLED;
  wire logic mon_on = ie_q && det_on;
  // Sampled mode only looks at the supply on a sample strobe
  wire logic look = mon_on && (!sampled || sample_strobe);
  logic below_q;
  logic seen_q;
  logic flag_q;
  wire logic fell = look && seen_q && supply_below_warning && !below_q;
  wire logic rose = look && seen_q && !supply_below_warning && below_q;
  // First look after enable counts as a crossing for either direction
  wire logic first = look && !seen_q && cfg_q == `BMC_CROSS_EITHER;
  wire logic hit_cfg = (cfg_q == `BMC_CROSS_ABOVE && fell) ||
                       (cfg_q == `BMC_CROSS_BELOW && rose) ||
                       (cfg_q == `BMC_CROSS_EITHER && (fell || rose)) || first;
  // Sampling only honours the single documented code; direction kept as field says
  wire logic hit = sampled ? (cfg_q == `BMC_CROSS_BELOW && rose) : hit_cfg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      below_q <= 1'b0;
      seen_q <= 1'b0;
    end else begin
      if (look) below_q <= supply_below_warning;
      seen_q <= mon_on ? (seen_q | look) : 1'b0;
    end
  end
  // Set beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) flag_q <= 1'b0;
    else if (hit) flag_q <= 1'b1;
    else if (wr_flag && pwdata[0]) flag_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Outputs and read mux
  // ----------------------------------------------------------------
  assign warning_irq = ie_q && flag_q;
  assign detector_mode = mode_eff;
  assign sample_rate_select = samp_q;
  assign threshold_level = lvl_q;
  assign warning_level_select = wlvl_q;
  assign monitor_enable = mon_on;
  logic asleep_q;
  // Remember sleep so the wake-up edge can be seen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) asleep_q <= 1'b0;
    else asleep_q <= deep_sleep;
  end
  // No ready input from the analog side, so the hold lasts one cycle
  assign wake_hold = loaded_q && asleep_q && !deep_sleep && active_q == `BMC_MODE_ON_HOLD;
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    unique case (idx)
      `BMC_IDX_MODE_CTRL: rd_byte = {3'h0, samp_q, active_q, sleep_q};
      `BMC_IDX_LEVEL_SEL: rd_byte = {5'h00, lvl_q};
      `BMC_IDX_WARN_LVL: rd_byte = {6'h00, wlvl_q};
      `BMC_IDX_WARN_INT: rd_byte = {5'h00, cfg_q, ie_q};
      `BMC_IDX_WARN_FLAGS: rd_byte = {7'h00, flag_q};
      `BMC_IDX_WARN_STAT: rd_byte = {7'h00, below_q};
      `BMC_IDX_KEY: rd_byte = {5'h00, key_cnt_q};
      default: rd_byte = 8'h00;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite) prdata <= {24'h00_0000, rd_byte};
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Slices kept as named wires so that sampled-value functions see plain signals
  wire logic [1:0] chk_fz_act = brownout_config_fuse[`BMC_FUSE_ACTIVE_LSB +: 2];
  wire logic [1:0] chk_fz_slp = brownout_config_fuse[`BMC_FUSE_SLEEP_LSB +: 2];
  wire logic [2:0] chk_fz_lvl = brownout_config_fuse[`BMC_FUSE_LVL_LSB +: 3];
  wire logic chk_fz_samp = brownout_config_fuse[`BMC_FUSE_SAMP_BIT];
  wire logic [1:0] chk_wd2 = pwdata[1:0];
  wire logic [2:0] chk_wd3 = pwdata[2:0];

  // Request is the plain product of enable and flag
  irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    warning_irq == (ie_q && flag_q))
    else $error("request not tied to flag");

  // A crossing must never be lost
  flag_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
    hit |=> flag_q)
    else $error("crossing lost");

  // Detector off keeps the monitor off
  off_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    !det_on |-> !monitor_enable)
    else $error("monitor on with detector off");

  // Sampled mode honours one code only
  samp_code_a: assert property (@(posedge pclk) disable iff (!presetn)
    (sampled && cfg_q != `BMC_CROSS_BELOW && !flag_q && !(wr_flag)) |=> !flag_q)
    else $error("sampled mode flagged wrong code");

  // Fuse-fixed fields never move once loaded
  fuse_fixed_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(loaded_q) |-> $stable(active_q) && $stable(lvl_q))
    else $error("fuse fields changed");

  // Write without a key is accepted but dropped
  nokey_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_mode && !key_open && loaded_q) |=> $stable(sleep_q))
    else $error("unkeyed write changed sleep mode");

  // Key opens the full window
  key_window_a: assert property (@(posedge pclk) disable iff (!presetn)
    key_ok |=> key_cnt_q == `BMC_KEY_WINDOW)
    else $error("key window not opened");

  // Deep sleep runs the detector from the sleep field
  sleep_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
    deep_sleep |-> detector_mode == sleep_q)
    else $error("sleep mode not used");

  // Offsets above the key register read zero
  rsvd_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && idx > `BMC_IDX_KEY) |=> prdata == 32'h0)
    else $error("reserved read nonzero");

  // No wait states, so a refused write still completes
  pready_one_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready == 1'b1)
    else $error("bus stalled");

  // Awake mode is taken from the fuse word
  load_act_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!loaded_q && fuse_valid) |=> active_q == $past(chk_fz_act))
    else $error("awake mode not loaded");

  // Threshold code is taken from the fuse word
  load_lvl_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!loaded_q && fuse_valid) |=> lvl_q == $past(chk_fz_lvl))
    else $error("threshold not loaded");

  // Sample rate is taken from the fuse word
  load_samp_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!loaded_q && fuse_valid) |=> samp_q == $past(chk_fz_samp))
    else $error("sample rate not loaded");

  // Sleep mode resets from the fuse word
  load_slp_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!loaded_q && fuse_valid) |=> sleep_q == $past(chk_fz_slp))
    else $error("sleep mode not loaded");

  // Reserved sleep code is refused even with the key
  sleep_rsvd_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_mode && loaded_q && chk_wd2 == `BMC_MODE_ON_HOLD) |=> $stable(sleep_q))
    else $error("reserved sleep code stored");

  // Keyed write lands the new sleep mode
  sleep_take_a: assert property (@(posedge pclk) disable iff (!presetn)
    (loaded_q && sleep_wr) |=> sleep_q == $past(chk_wd2))
    else $error("keyed write lost");

  // The protected write uses up the window
  key_close_a: assert property (@(posedge pclk) disable iff (!presetn)
    sleep_wr |=> key_cnt_q == 3'h0)
    else $error("window left open");

  // Each instruction shortens the window by one
  key_count_a: assert property (@(posedge pclk) disable iff (!presetn)
    (key_open && cpu_instr_done && !key_ok && !sleep_wr) |=>
      key_cnt_q == $past(key_cnt_q) - 3'h1)
    else $error("window count wrong");

  // Awake operation uses the fuse mode
  awake_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!deep_sleep && loaded_q) |-> detector_mode == active_q)
    else $error("awake mode not used");

  // Monitor level register takes the write
  lvl_take_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_lvl |=> wlvl_q == $past(chk_wd2))
    else $error("level write lost");

  // Interrupt control register takes the write
  int_take_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_int |=> {cfg_q, ie_q} == $past(chk_wd3))
    else $error("interrupt control write lost");

  // Writing one clears the flag when nothing sets it
  flag_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_flag && pwdata[0] && !hit) |=> !flag_q)
    else $error("flag not cleared");

  // Flag holds until cleared or set by a crossing
  flag_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!hit && !(wr_flag && pwdata[0])) |=> $stable(flag_q))
    else $error("flag moved on its own");

  // Set beats a clear in the same cycle
  set_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
    (hit && wr_flag && pwdata[0]) |=> flag_q)
    else $error("clear beat a crossing");

  // Flag is only set while the detector runs
  off_no_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!det_on && !flag_q) |=> !flag_q)
    else $error("flag set with detector off");

  // Sampled monitor ignores the supply between samples
  samp_look_a: assert property (@(posedge pclk) disable iff (!presetn)
    (sampled && !sample_strobe) |=> $stable(below_q))
    else $error("sampled monitor looked early");

  // Either-direction config flags on the first look outside sampled mode
  either_first_a: assert property (@(posedge pclk) disable iff (!presetn)
    (look && !seen_q && !sampled && cfg_q == `BMC_CROSS_EITHER) |=> flag_q)
    else $error("first look did not flag");

  // Status follows the supply at every look
  status_track_a: assert property (@(posedge pclk) disable iff (!presetn)
    look |=> below_q == $past(supply_below_warning))
    else $error("status stale");

  // Rising past the threshold flags with code one
  rise_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cfg_q == `BMC_CROSS_BELOW && rose) |=> flag_q)
    else $error("rising crossing missed");

  // Upper read bits are always zero
  rd_upper_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite) |=> prdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");

  // Wake hold only after waking in hold mode
  wake_only_a: assert property (@(posedge pclk) disable iff (!presetn)
    wake_hold |-> (active_q == `BMC_MODE_ON_HOLD && !deep_sleep))
    else $error("wake hold out of place");

  // Main scenarios
  cv_irq_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(warning_irq));
  cv_sleep_c: cover property (@(posedge pclk) disable iff (!presetn) sleep_wr);
  cv_samp_c: cover property (@(posedge pclk) disable iff (!presetn) sampled && hit);
  cv_clear_c: cover property (@(posedge pclk) disable iff (!presetn) wr_flag && flag_q);
  cv_wake_c: cover property (@(posedge pclk) disable iff (!presetn) wake_hold);

endmodule : bmc_top

/* File: verification/bmc_far_model.sv */
module bmc_far_model #(
  parameter logic [7:0] FUSE_WORD = 8'h56
) (
  input wire logic pclk,
  input wire logic presetn,
  output logic [7:0] brownout_config_fuse,
  output logic fuse_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] dly_q;
  // Loader settles late; word is garbage until valid
  assign fuse_valid = (dly_q == 2'h3);
  assign brownout_config_fuse = fuse_valid ? FUSE_WORD : ~FUSE_WORD;
  // Delay counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) dly_q <= 2'h0;
    else if (dly_q != 2'h3) dly_q <= dly_q + 2'h1;
  end
endmodule : bmc_far_model

/* File: verification/bmc_top_tb.sv */
module bmc_top_tb
  import bmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [5:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] fuse;
  logic fuse_valid, deep_sleep, instr, below, strobe;
  logic [1:0] det_mode, wlvl;
  logic srate, mon_en, whold, irq;
  logic [2:0] thr;
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;
  // ----------------------------------------
  // Clock, harnesses
  // ----------------------------------------
  always #50 pclk = ~pclk;
  bmc_far_model i_bmc_far_model (.pclk(pclk), .presetn(presetn),
    .brownout_config_fuse(fuse), .fuse_valid(fuse_valid));
  bmc_top i_bmc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .brownout_config_fuse(fuse), .fuse_valid(fuse_valid),
    .deep_sleep(deep_sleep), .cpu_instr_done(instr),
    .supply_below_warning(below), .sample_strobe(strobe),
    .detector_mode(det_mode), .sample_rate_select(srate),
    .threshold_level(thr), .warning_level_select(wlvl),
    .monitor_enable(mon_en), .wake_hold(whold), .warning_irq(irq));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic give_verdict;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // One APB transfer; held until pready seen high
  task automatic apb(input logic w, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask : wr
  task automatic rc(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    check(r, e);
  endtask : rc
  // Instruction pulses count down the key window
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge pclk);
      instr <= 1'b1;
      @(posedge pclk);
      instr <= 1'b0;
    end
  endtask : pulses
  task automatic drive(input logic s, input logic b);
    @(posedge pclk);
    deep_sleep <= s;
    below <= b;
    repeat (3) @(posedge pclk);
  endtask : drive
  // One sample instant with the supply level given
  task automatic strobe_at(input logic b);
    @(posedge pclk);
    below <= b;
    strobe <= 1'b1;
    @(posedge pclk);
    strobe <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : strobe_at
  // Hang guard, well above the expected run length
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      give_verdict();
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {pclk, presetn, psel, penable, pwrite, deep_sleep, instr, below, strobe} = 9'h000;
    paddr = 6'h00;
    pwdata = 32'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    rc(6'h00, 32'h16);
    rc(6'h04, 32'h02);
    check({28'h0, srate, thr}, 32'hA);
    check({30'h0, pslverr, whold}, 32'h0);
    wr(6'h00, 32'hFF);
    wr(6'h04, 32'hFF);
    rc(6'h00, 32'h16);
    rc(6'h04, 32'h02);
    // Key then four instructions: window must be shut
    wr(6'h30, 32'hD8);
    pulses(4);
    wr(6'h00, 32'h00);
    rc(6'h00, 32'h16);
    wr(6'h30, 32'hD8);
    wr(6'h00, 32'h03);
    rc(6'h00, 32'h16);
    wr(6'h30, 32'hD8);
    pulses(3);
    wr(6'h00, 32'h00);
    rc(6'h00, 32'h14);
    wr(6'h00, 32'h01);
    rc(6'h00, 32'h14);
    wr(6'h24, 32'h05);
    rc(6'h24, 32'h05);
    check({30'h0, det_mode}, 32'h1);
    check({31'h0, mon_en}, 32'h1);
    drive(1'b1, 1'b0);
    check({29'h0, det_mode, mon_en}, 32'h0);
    drive(1'b0, 1'b0);
    check({29'h0, det_mode, mon_en}, 32'h3);
    wr(6'h28, 32'h01);
    drive(1'b0, 1'b1);
    rc(6'h28, 32'h01);
    check({31'h0, irq}, 32'h1);
    rc(6'h2C, 32'h01);
    wr(6'h28, 32'h01);
    rc(6'h28, 32'h00);
    check({31'h0, irq}, 32'h0);
    wr(6'h24, 32'h04);
    drive(1'b0, 1'b0);
    rc(6'h28, 32'h00);
    check({31'h0, irq}, 32'h0);
    // Sampled sleep mode: only code one flags, on a rise past the threshold
    wr(6'h30, 32'hD8);
    wr(6'h00, 32'h02);
    rc(6'h00, 32'h16);
    wr(6'h24, 32'h01);
    drive(1'b1, 1'b0);
    check({30'h0, det_mode}, 32'h2);
    strobe_at(1'b1);
    strobe_at(1'b0);
    rc(6'h28, 32'h00);
    wr(6'h24, 32'h03);
    strobe_at(1'b1);
    strobe_at(1'b0);
    rc(6'h28, 32'h01);
    check({31'h0, irq}, 32'h1);
    rc(6'h2C, 32'h00);
    wr(6'h20, 32'h02);
    rc(6'h20, 32'h02);
    check({30'h0, wlvl}, 32'h2);
    wr(6'h08, 32'hFF);
    rc(6'h08, 32'h00);
    give_verdict();
  end
endmodule : bmc_top_tb
